// ==== crs_pkg.sv ====
`default_nettype none
package crs_pkg;
	// APB register byte offsets
	localparam logic [11:0] OFF_MODE = 12'h000;
	localparam logic [11:0] OFF_CLK = 12'h004;
	localparam logic [11:0] OFF_PRESC = 12'h008;
	localparam logic [11:0] OFF_STATUS = 12'h00C;
	localparam logic [11:0] OFF_WDOG = 12'h010;
	// Mode register fields
	localparam int MODE_SEL_LO = 0;
	localparam int MODE_SWRST_BIT = 3;
	// Clock register fields
	localparam int CLK_WDRST_BIT = 6;
	localparam int CLK_MAINSRC_BIT = 0;
	localparam int CLK_STABLE_BIT = 1;
	// Processor mode encodings
	localparam logic [1:0] PMODE_SINGLE = 2'h0;
	localparam logic [1:0] PMODE_EXPAND = 2'h1;
	localparam logic [1:0] PMODE_PROHIB = 2'h2;
	localparam logic [1:0] PMODE_MICRO = 2'h3;
	// Reset values
	localparam logic [7:0] PRESC_RST = 8'h00;
	localparam logic [7:0] CLK_RST = 8'h00;
	localparam logic [7:0] WDOG_RST = 8'hFF;
	// Least reset low time in main oscillator cycles
	localparam int RST_MIN_CYC = 20;
	// Stretch count loaded on the trigger; the internal reset stays asserted two cycles longer than this
	localparam int RST_STRETCH_CYC = 8;

	typedef enum logic [1:0] {
		CRS_RUN = 2'b00,
		CRS_HOLD = 2'b01,
		CRS_RELEASE = 2'b11
	} crs_state_e;

	typedef struct packed {
		logic hw;
		logic sw;
		logic wd;
	} crs_cause_s;

	typedef struct packed {
		logic [2:0] addr_oe;
		logic wr_n;
		logic rd_n;
		logic bclk_en;
		logic hold_ack_n;
		logic ready_in_oe;
		logic hold_in_oe;
		logic upper_byte_oe;
		logic data_hi_oe;
	} crs_pins_s;
endpackage
`default_nettype wire

// ==== crs_rst_src.sv ====
`default_nettype none
module crs_rst_src #(
	parameter int LOW_CYC = 20
) (
	input wire logic clk, // Oscillator clock
	input wire logic start, // Begin a reset pulse
	output logic reset_pin_n // Reset pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// Starts low so power-on sees a full pulse
	int cnt = LOW_CYC;
	always @(posedge clk)
		if (start)
			cnt <= LOW_CYC;
		else if (cnt > 0)
			cnt <= cnt - 1;
	assign reset_pin_n = (cnt == 0);
endmodule
`default_nettype wire

// ==== crs_sync.sv ====
`default_nettype none
module crs_sync (
	input wire logic clk, // Clock
	input wire logic rst_init_n, // Preset to low
	input wire logic d, // Async level
	output logic q // Synchronised level
);
	logic s1_q;
	logic s2_q;
	always_ff @(posedge clk)
	begin
		if (!rst_init_n)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
		end
		else
		begin
			s1_q <= d;
			s2_q <= s1_q;
		end
	end
	assign q = s2_q;
endmodule
`default_nettype wire

// ==== crs_top.sv ====
// Register access over APB and the register offsets were decided locally.
`default_nettype none
// Operation
// - Reset pin low forces pins to reset state and restarts oscillator.
// - Core and registers leave reset on the pin's rising edge, fetch vector.
// - Reset never clears internal RAM; writes during reset are blocked.
// - Boot strap high: ready/hold in, addresses out, strobes high, bus clock out.
// - During reset with boot strap high, hold acknowledge follows the hold request input.
// - Writing 1 to the software reset request bit resets the chip.
// - Software and watchdog resets keep the processor mode bits.
// - Watchdog underflow with reset select set resets the chip.
// - Prescaler keeps its value except on hardware reset.
// - Mode field: 00 single, 01 expansion, 11 microprocessor, 10 prohibited.
// - Hardware reset with boot strap high enters microprocessor mode.
module crs_top #(
	parameter int STRETCH = crs_pkg::RST_STRETCH_CYC
) (
	input wire logic clk, // 200 MHz system clock
	input wire logic rst, // Power-on reset, sync active high
	input wire logic reset_pin_n, // External reset pin, active low
	input wire logic boot_mode_strap_pin, // High selects external bus boot
	input wire logic data_width_strap, // High selects 8-bit bus
	input wire logic hold_req_n, // Hold request pin, active low
	input wire logic wdog_tick, // Watchdog decrement pulse
	input wire logic ram_wr_req, // Core RAM write request
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [11:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	output logic core_rst, // CPU and register reset, high active
	output logic osc_rst, // Oscillator restart
	output logic vector_fetch, // Pulse: fetch from reset vector
	output logic ram_wr_en, // Gated RAM write enable
	output logic [1:0] proc_mode, // Current processor mode
	output logic [7:0] presc_val, // Count source prescaler value
	output crs_pkg::crs_pins_s pins, // Pin states
	output logic pins_in_reset // Pins forced to reset state
);
	//////////////////////////////////////////////////////////////////////////
	logic pin_n_sync;
	crs_sync u_sync (
		.clk(clk),
		.rst_init_n(~rst),
		.d(reset_pin_n),
		.q(pin_n_sync)
	);

	//////////////////////////////////////////////////////////////////////////
	crs_pkg::crs_state_e st_q, st_d;
	logic [7:0] cnt_q, cnt_d;
	crs_pkg::crs_cause_s cause_q, cause_d;
	logic [1:0] mode_q, mode_d;
	logic [7:0] clk_q, clk_d;
	logic [7:0] presc_q, presc_d;
	logic [7:0] wdog_q, wdog_d;
	logic [31:0] rdata_q, rdata_d;
	logic vec_q, vec_d;
	logic hw_rst, sw_req, wd_req, wr_acc, rd_acc;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction

	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && !penable && !pwrite;
	assign hw_rst = rst || !pin_n_sync;
	// Request honoured regardless of clock selection; software must guard
	assign sw_req = wr_acc && hit(paddr, crs_pkg::OFF_MODE)
		&& pwdata[crs_pkg::MODE_SWRST_BIT] && st_q == crs_pkg::CRS_RUN;
	assign wd_req = wdog_tick && wdog_q == 8'h00
		&& clk_q[crs_pkg::CLK_WDRST_BIT] && st_q == crs_pkg::CRS_RUN;

	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		cause_d = cause_q;
		vec_d = 1'b0;
		case (st_q)
			crs_pkg::CRS_RUN:
			begin
				if (sw_req || wd_req)
				begin
					st_d = crs_pkg::CRS_HOLD;
					cnt_d = 8'(STRETCH);
					cause_d = '{hw: 1'b0, sw: sw_req, wd: wd_req};
				end
			end
			crs_pkg::CRS_HOLD:
			begin
				if (cnt_q != 8'h00)
					cnt_d = cnt_q - 8'h01;
				else
					st_d = crs_pkg::CRS_RELEASE;
			end
			crs_pkg::CRS_RELEASE:
			begin
				st_d = crs_pkg::CRS_RUN;
				vec_d = 1'b1;
			end
			default: st_d = crs_pkg::CRS_RUN;
		endcase
		if (hw_rst)
		begin
			// Held while pin is low; release happens on the synchronised rise
			st_d = crs_pkg::CRS_RELEASE;
			cnt_d = 8'h00;
			cause_d = '{hw: 1'b1, sw: 1'b0, wd: 1'b0};
			vec_d = 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		mode_d = mode_q;
		clk_d = clk_q;
		presc_d = presc_q;
		wdog_d = wdog_q;
		rdata_d = rdata_q;
		if (wdog_tick)
			wdog_d = wdog_q - 8'h01;
		if (wr_acc)
		begin
			if (hit(paddr, crs_pkg::OFF_MODE) && pwdata[1:0] != crs_pkg::PMODE_PROHIB)
				mode_d = pwdata[1:0];
			if (hit(paddr, crs_pkg::OFF_CLK))
				clk_d = pwdata[7:0];
			if (hit(paddr, crs_pkg::OFF_PRESC))
				presc_d = pwdata[7:0];
			if (hit(paddr, crs_pkg::OFF_WDOG))
				wdog_d = pwdata[7:0];
		end
		if (rd_acc)
		begin
			rdata_d = 32'h0000_0000;
			case (paddr)
				crs_pkg::OFF_MODE: rdata_d[1:0] = mode_q;
				crs_pkg::OFF_CLK: rdata_d[7:0] = clk_q;
				crs_pkg::OFF_PRESC: rdata_d[7:0] = presc_q;
				crs_pkg::OFF_STATUS: rdata_d[4:0] = {st_q, cause_q};
				crs_pkg::OFF_WDOG: rdata_d[7:0] = wdog_q;
				default: rdata_d = 32'h0000_0000;
			endcase
		end
		if (st_q != crs_pkg::CRS_RUN)
		begin
			// Mode and prescaler survive software and watchdog reset
			clk_d = crs_pkg::CLK_RST;
			wdog_d = crs_pkg::WDOG_RST;
		end
		if (hw_rst)
		begin
			mode_d = boot_mode_strap_pin ? crs_pkg::PMODE_MICRO
				: crs_pkg::PMODE_SINGLE;
			presc_d = crs_pkg::PRESC_RST;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_q <= crs_pkg::CRS_RELEASE;
			cnt_q <= 8'h00;
			cause_q <= '{hw: 1'b1, sw: 1'b0, wd: 1'b0};
			vec_q <= 1'b0;
			mode_q <= crs_pkg::PMODE_SINGLE;
			clk_q <= crs_pkg::CLK_RST;
			presc_q <= crs_pkg::PRESC_RST;
			wdog_q <= crs_pkg::WDOG_RST;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			cause_q <= cause_d;
			vec_q <= vec_d;
			mode_q <= mode_d;
			clk_q <= clk_d;
			presc_q <= presc_d;
			wdog_q <= wdog_d;
			rdata_q <= rdata_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	logic in_rst;
	assign in_rst = hw_rst || st_q != crs_pkg::CRS_RUN;
	assign core_rst = in_rst;
	assign osc_rst = hw_rst;
	assign vector_fetch = vec_q;
	// RAM is never cleared; writes are cut so reset cannot corrupt a word
	assign ram_wr_en = ram_wr_req && !in_rst;
	assign proc_mode = mode_q;
	assign presc_val = presc_q;
	assign pins_in_reset = in_rst;
	assign prdata = rdata_q;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	always_comb
	begin
		pins = '0;
		pins.wr_n = 1'b1;
		pins.rd_n = 1'b1;
		pins.hold_ack_n = 1'b1;
		if (in_rst && boot_mode_strap_pin)
		begin
			pins.addr_oe = 3'h7;
			pins.bclk_en = 1'b1;
			pins.upper_byte_oe = 1'b1;
			pins.hold_ack_n = hold_req_n;
			pins.data_hi_oe = 1'b0;
			pins.ready_in_oe = 1'b0;
			pins.hold_in_oe = 1'b0;
		end
		if (data_width_strap)
			pins.data_hi_oe = 1'b0;
	end
endmodule
`default_nettype wire

// ==== crs_top_assertions.sv ====
`default_nettype none
module crs_top_assertions (
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire logic boot_mode_strap_pin, // Boot strap
	input wire logic hold_req_n, // Hold request
	input wire logic ram_wr_req, // RAM request
	input wire logic psel, // APB
	input wire logic penable, // APB
	input wire logic pwrite, // APB
	input wire logic [11:0] paddr, // APB
	input wire logic [31:0] pwdata, // APB
	input wire logic core_rst, // Core reset
	input wire logic osc_rst, // Osc reset
	input wire logic vector_fetch, // Fetch pulse
	input wire logic ram_wr_en, // RAM enable
	input wire logic [1:0] proc_mode, // Mode
	input wire logic [7:0] presc_val, // Prescaler
	input wire crs_pkg::crs_pins_s pins, // Pins
	input wire logic pins_in_reset // Pin reset flag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	sequence sw_req;
		psel && penable && pwrite && paddr == crs_pkg::OFF_MODE && pwdata[3] && !core_rst;
	endsequence
	sequence held_8;
		core_rst [*8];
	endsequence
	a_sw_reset: assert property (sw_req |=> held_8)
		else $error("soft reset not held");
	a_ram_gate: assert property (ram_wr_en == (ram_wr_req && !core_rst))
		else $error("ram write not gated");
	a_fetch_pulse: assert property (vector_fetch |=> !vector_fetch)
		else $error("fetch pulse too long");
	a_fetch_edge: assert property ($fell(core_rst) |-> vector_fetch)
		else $error("release without fetch");
	a_pin_flag: assert property (pins_in_reset == core_rst && (!osc_rst || core_rst))
		else $error("pins not in reset");
	a_mode_legal: assert property (proc_mode != crs_pkg::PMODE_PROHIB)
		else $error("prohibited mode");
	a_presc_keep: assert property ($changed(presc_val) |-> osc_rst || $past(osc_rst)
		|| $past(psel && penable && pwrite && paddr == crs_pkg::OFF_PRESC))
		else $error("prescaler lost");
	a_strap_pins: assert property (pins_in_reset && boot_mode_strap_pin |-> pins.wr_n
		&& pins.rd_n && pins.bclk_en && !pins.ready_in_oe && !pins.hold_in_oe)
		else $error("bad boot pins");
	a_hold_ack: assert property (pins_in_reset && boot_mode_strap_pin
		|-> pins.hold_ack_n == hold_req_n)
		else $error("hold ack wrong");
endmodule
bind crs_top crs_top_assertions u_chk (
	.clk(clk),
	.rst(rst),
	.boot_mode_strap_pin(boot_mode_strap_pin),
	.hold_req_n(hold_req_n),
	.ram_wr_req(ram_wr_req),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.core_rst(core_rst),
	.osc_rst(osc_rst),
	.vector_fetch(vector_fetch),
	.ram_wr_en(ram_wr_en),
	.proc_mode(proc_mode),
	.presc_val(presc_val),
	.pins(pins),
	.pins_in_reset(pins_in_reset)
);
`default_nettype wire

// ==== test_chip_reset_sequencer.sv ====
`default_nettype none
module test_chip_reset_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, reset_pin_n, boot_mode_strap_pin, data_width_strap, hold_req_n, wdog_tick;
	logic ram_wr_req, psel, penable, pwrite, pready, pslverr, core_rst, vector_fetch, start;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] proc_mode;
	logic [7:0] presc_val;
	int err_total, compares, mode_m, presc_m, n;
	crs_top u_crs_top (.clk, .rst, .reset_pin_n, .boot_mode_strap_pin, .data_width_strap,
		.hold_req_n, .wdog_tick, .ram_wr_req, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .core_rst, .osc_rst(), .vector_fetch, .ram_wr_en(),
		.proc_mode, .presc_val, .pins(), .pins_in_reset());
	crs_rst_src u_crs_rst_src (.clk, .start, .reset_pin_n);
	////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) {hold_req_n, ram_wr_req} <= 2'($urandom);
	task automatic conclude;
		if (err_total == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do
			@(posedge clk);
		while (pready !== 1'h1);
		rd = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wait_vf;
		n = 0;
		while (vector_fetch !== 1'h1 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		chk(32'(n < 200), 32'h1);
		chk(32'(core_rst), 32'h0);
	endtask
	// Status holds {state, hw, sw, wd}; state reads back as run here
	task automatic verify(input int cause_m);
		apb(0, crs_pkg::OFF_MODE, 0);
		chk(32'(rd[1:0]), mode_m);
		chk(32'(proc_mode), mode_m);
		apb(0, crs_pkg::OFF_PRESC, 0);
		chk(32'(rd[7:0]), presc_m);
		apb(0, crs_pkg::OFF_STATUS, 0);
		chk(rd, cause_m);
		chk(32'(pslverr), 32'h0);
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(32'hD68EB1F0));
		{rst, boot_mode_strap_pin, wdog_tick, psel, penable, pwrite, start} = 7'h60;
		{err_total, compares, paddr, pwdata} = 0;
		data_width_strap = 1'($urandom);
		{hold_req_n, ram_wr_req} = 2'h2;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		mode_m = 3;
		presc_m = 0;
		wait_vf;
		verify(4);
		for (int m = 3; m >= 0; m--)
		begin
			apb(1, crs_pkg::OFF_MODE, m);
			if (m != 2)
				mode_m = m;
			verify(4);
		end
		presc_m = $urandom_range(255);
		apb(1, crs_pkg::OFF_PRESC, presc_m);
		apb(1, crs_pkg::OFF_CLK, 32'h3);
		// Expansion mode rides along, so retention differs from both strap values
		apb(1, crs_pkg::OFF_MODE, 32'h9);
		mode_m = 1;
		wait_vf;
		verify(2);
		apb(1, crs_pkg::OFF_CLK, 32'h43);
		apb(1, crs_pkg::OFF_WDOG, 0);
		@(posedge clk);
		wdog_tick <= 1'h1;
		@(posedge clk);
		wdog_tick <= 1'h0;
		wait_vf;
		verify(1);
		apb(0, 12'h0FC, 0);
		chk(rd, 0);
		boot_mode_strap_pin <= 1'h0;
		start <= 1'h1;
		@(posedge clk);
		start <= 1'h0;
		mode_m = 0;
		presc_m = 0;
		wait_vf;
		verify(4);
		conclude;
	end
	initial
	begin
		#20000;
		err_total++;
		conclude;
	end
endmodule
`default_nettype wire
